// ---- verilog/macsr_pkg.sv ----
// constants and types of the multiply-accumulate shift, repeat and trap control block
// How it works
// - shifter takes 40-bit accumulator; no shift, or arithmetic left/right up to 8
// - left shifts update guard, overflow and saturation flags; saturate when enabled
// - left shifts update carry, a left shift by zero clears it; right shifts never touch carry
// - repeat unit runs selected instructions up to 8192 times per sequence
// - repeat count from 5-bit immediate up to 31 or repeat_word bits 12..0
// - repeat_word count N executes the instruction N+1 times; an immediate N of 1 to 31 executes it N times, 0 once
// - each iteration tests count for zero; ends, else decrements and repeats
// - repeat_active_flag stays set until final execution is reached
// - immediate repeat loads repeat_word count with immediate minus two
// - interrupt halts a repeat sequence; remaining repetitions resume on return
// - while suspended, active flag stays set, count holds remaining minus one
// - interrupt only with global enable; flag newly set plus its mask triggers
// - request sets coproc_irq_pending; service clears it or trap is retaken
// - delivered as class B trap, number ah priority I, sets trap flag bit 6
// - flags update at execute; vector instruction enters pipeline 3 cycles later
// - stacked return address is not the triggering instruction's address
// - operands two's complement; only multiply-accumulate selects unsigned per operand
// - fraction_shift_bit set gives 1.[N-1] fractional form, product shifted left one
// - rounding adds one at bit 15 of acc_low_word then clears acc_low_word
// - accumulator is high word, low word and guard byte in status low byte
// - saturation forces 00_7fff_ffff or ff_8000_0000 (00_7fff_0000 after round) and sets sticky flag
// - guard_bits_flag set when top eight bits hold significant non-sign bits
package macsr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_ACC_LOW  = 8'h00;
  localparam logic [7:0] OFS_ACC_HIGH = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_CONTROL  = 8'h0c;
  localparam logic [7:0] OFS_REPEAT   = 8'h10;
  localparam logic [7:0] OFS_TRAPFLAG = 8'h14;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_CARRY = 8;
  localparam int ST_OVF   = 9;
  localparam int ST_GUARD = 10;
  localparam int ST_SAT   = 11;
  localparam int ST_PEND  = 15;
  localparam int CW_FRAC  = 0;
  localparam int CW_ASAT  = 1;
  localparam int CW_CM    = 8;
  localparam int CW_VM    = 9;
  localparam int CW_EM    = 10;
  localparam int CW_LM    = 11;
  localparam int CW_MIE   = 15;
  localparam int RW_ACT   = 15;
  localparam int CNT_W    = 13;
  localparam int TF_MAC   = 6;
  // ****************************************
  // values
  // ****************************************
  localparam logic [7:0]  TRAP_NUMBER  = 8'h0a;
  localparam logic [1:0]  TRAP_PRIO    = 2'h1;
  localparam int          TRAP_LAT     = 3;
  localparam logic [3:0]  SHIFT_MAX    = 4'h8;
  localparam logic [39:0] ROUND_ADD    = 40'h00_0000_8000;
  localparam logic [39:0] SAT_POS      = 40'h00_7fff_ffff;
  localparam logic [39:0] SAT_NEG      = 40'hff_8000_0000;
  localparam logic [15:0] CW_RST       = 16'h0000;

  typedef enum logic [2:0] {
    MACSR_NOP = 3'b000,
    MACSR_MAC = 3'b001,
    MACSR_SHL = 3'b010,
    MACSR_SHR = 3'b011,
    MACSR_RND = 3'b100
  } macsr_op_t;

  typedef enum logic [1:0] {
    MACSR_REP_NONE = 2'b00,
    MACSR_REP_IMM  = 2'b01,
    MACSR_REP_REG  = 2'b10
  } macsr_rep_t;

  typedef struct packed {
    macsr_op_t   op;
    logic [3:0]  shamt;
    macsr_rep_t  rep;
    logic [4:0]  rep_imm;
    logic        a_signed;
    logic        b_signed;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [15:0] next_addr;
  } macsr_cmd_t;
endpackage

// ---- verilog/macsr_core.sv ----
// multiply-accumulate shifter, repeat unit and coprocessor trap with apb registers
`timescale 1ns/1ns
module macsr_core (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 cmd_valid,
  input  wire macsr_pkg::macsr_cmd_t cmd,
  output logic                      cmd_ready,
  input  wire logic                 irq_enter,
  input  wire logic                 irq_return,
  output logic                      trap_req,
  output logic                      trap_vec_fetch,
  output logic      [7:0]           trap_number,
  output logic      [1:0]           trap_prio,
  output logic      [15:0]          trap_ret_addr
);
  import macsr_pkg::*;

  typedef enum logic [1:0] {
    MACSR_IDLE = 2'b00,
    MACSR_RUN  = 2'b01,
    MACSR_SUSP = 2'b10
  } macsr_state_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic guard_set(input logic [39:0] x);
    guard_set = ~(&x[39:31] | ~|x[39:31]);
  endfunction

  function automatic logic [39:0] sat_val(input logic neg);
    sat_val = neg ? SAT_NEG : SAT_POS;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [15:0]        acc_low_ff, acc_high_ff;
  logic [7:0]         acc_guard_ff;
  logic               carry_ff, ovf_ff, guard_ff, sat_ff, pend_ff;
  logic [15:0]        ctrl_ff;
  logic [CNT_W-1:0]   cnt_ff;
  logic               act_ff;
  logic               tflag_ff;
  macsr_state_t       state_ff;
  macsr_cmd_t         cmd_ff;
  logic [TRAP_LAT-1:0] lat_ff;
  logic [15:0]        ret_ff;
  logic [31:0]        prdata_ff;

  logic               accept, exec, wr, rd_setup;
  macsr_cmd_t         cur;
  logic [39:0]        acc, nxt_acc;
  logic               nxt_carry, nxt_guard, set_ovf, set_sat, upd_flags;
  logic               irq_event;
  logic [CNT_W-1:0]   start_cnt;
  logic               hit;

  assign acc       = {acc_guard_ff, acc_high_ff, acc_low_ff};
  assign cmd_ready = ce && (state_ff == MACSR_IDLE);
  assign accept    = cmd_valid && cmd_ready && (cmd.op != MACSR_NOP);
  assign exec      = ce && (accept || (state_ff == MACSR_RUN && !irq_enter));
  assign cur       = accept ? cmd : cmd_ff;
  assign wr        = ce && psel && penable && pwrite;
  assign rd_setup  = ce && psel && !penable && !pwrite;

  // ****************************************
  // datapath
  // ****************************************
  always_comb begin
    logic [47:0] sh;
    logic [40:0] sum;
    logic [40:0] usum;
    logic [16:0] pa, pb;
    logic [33:0] prod;
    logic [39:0] addend;
    logic [3:0]  n;
    logic        ov40;
    sh        = '0;
    sum       = '0;
    usum      = '0;
    pa        = '0;
    pb        = '0;
    prod      = '0;
    addend    = '0;
    ov40      = 1'b0;
    n         = (cur.shamt > SHIFT_MAX) ? SHIFT_MAX : cur.shamt;
    nxt_acc   = acc;
    nxt_carry = carry_ff;
    nxt_guard = guard_ff;
    set_ovf   = 1'b0;
    set_sat   = 1'b0;
    upd_flags = 1'b0;
    case (cur.op)
      MACSR_SHL: begin
        sh        = {{8{acc[39]}}, acc} << n;
        nxt_acc   = sh[39:0];
        nxt_carry = (n == 4'h0) ? 1'b0 : sh[40];
        ov40      = ~(&sh[47:39] | ~|sh[47:39]);
        upd_flags = 1'b1;
        if (ctrl_ff[CW_ASAT] && (guard_set(nxt_acc) || ov40)) begin
          nxt_acc = sat_val(acc[39]);
          set_sat = 1'b1;
        end
        set_ovf   = ov40;
        nxt_guard = guard_set(nxt_acc);
      end
      MACSR_SHR: begin
        nxt_acc = $signed(acc) >>> n;
      end
      MACSR_MAC, MACSR_RND: begin
        if (cur.op == MACSR_MAC) begin
          pa     = {cur.a_signed & cur.op_a[15], cur.op_a};
          pb     = {cur.b_signed & cur.op_b[15], cur.op_b};
          prod   = 34'($signed(pa) * $signed(pb));
          if (ctrl_ff[CW_FRAC]) begin
            prod = {prod[32:0], 1'b0};
          end
          // extend from the full product so an unsigned 32-bit result stays positive
          addend = {{6{prod[33]}}, prod[33:0]};
        end else begin
          addend = ROUND_ADD;
        end
        sum       = {acc[39], acc} + {addend[39], addend};
        usum      = {1'b0, acc} + {1'b0, addend};
        ov40      = sum[40] ^ sum[39];
        nxt_acc   = sum[39:0];
        nxt_carry = usum[40];
        upd_flags = 1'b1;
        if (ctrl_ff[CW_ASAT] && (guard_set(nxt_acc) || ov40)) begin
          nxt_acc = sat_val(sum[40]);
          set_sat = 1'b1;
        end
        if (cur.op == MACSR_RND) begin
          nxt_acc[15:0] = 16'h0000;
        end
        set_ovf   = ov40;
        nxt_guard = guard_set(nxt_acc);
      end
      default: begin
        nxt_acc = acc;
      end
    endcase
  end

  // ****************************************
  // accumulator
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_low_ff   <= 16'h0000;
      acc_high_ff  <= 16'h0000;
      acc_guard_ff <= 8'h00;
    end else if (exec) begin
      acc_low_ff   <= nxt_acc[15:0];
      acc_high_ff  <= nxt_acc[31:16];
      acc_guard_ff <= nxt_acc[39:32];
    end else if (wr) begin
      if (paddr == OFS_ACC_LOW) begin
        acc_low_ff <= pwdata[15:0];
      end else if (paddr == OFS_ACC_HIGH) begin
        acc_high_ff <= pwdata[15:0];
      end else if (paddr == OFS_STATUS) begin
        acc_guard_ff <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // status flags, execute-stage update
  // ****************************************
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_ff <= 1'b0;
      ovf_ff   <= 1'b0;
      guard_ff <= 1'b0;
      sat_ff   <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == OFS_STATUS) begin
        carry_ff <= pwdata[ST_CARRY];
        ovf_ff   <= pwdata[ST_OVF];
        guard_ff <= pwdata[ST_GUARD];
        sat_ff   <= pwdata[ST_SAT];
      end
      if (exec && upd_flags) begin
        carry_ff <= nxt_carry;
        guard_ff <= nxt_guard;
        if (set_ovf) begin
          ovf_ff <= 1'b1;
        end
        if (set_sat) begin
          sat_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CW_RST;
    end else if (wr && paddr == OFS_CONTROL) begin
      ctrl_ff <= pwdata[15:0];
    end
  end

  // ****************************************
  // interrupt and trap
  // ****************************************
  // only a rising flag triggers; a flag left set does not re-fire
  assign irq_event = exec && upd_flags && ctrl_ff[CW_MIE] && (
                     (nxt_carry && !carry_ff && ctrl_ff[CW_CM]) ||
                     (set_ovf && !ovf_ff && ctrl_ff[CW_VM]) ||
                     (nxt_guard && !guard_ff && ctrl_ff[CW_EM]) ||
                     (set_sat && !sat_ff && ctrl_ff[CW_LM]));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff  <= 1'b0;
      tflag_ff <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == OFS_STATUS) begin
        pend_ff <= pwdata[ST_PEND];
      end
      if (wr && paddr == OFS_TRAPFLAG) begin
        tflag_ff <= pwdata[TF_MAC];
      end
      if (irq_event) begin
        pend_ff  <= 1'b1;
        tflag_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_ff <= '0;
    end else if (ce) begin
      lat_ff <= {lat_ff[TRAP_LAT-2:0], irq_event};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_ff <= 16'h0000;
    end else if (irq_event) begin
      ret_ff <= cur.next_addr;
    end
  end

  assign trap_req       = pend_ff;
  assign trap_vec_fetch = lat_ff[TRAP_LAT-1];
  assign trap_number    = TRAP_NUMBER;
  assign trap_prio      = TRAP_PRIO;
  assign trap_ret_addr  = ret_ff;

  // ****************************************
  // repeat unit
  // ****************************************
  // immediate zero means a single execution, nothing to repeat
  assign start_cnt = (cmd.rep == MACSR_REP_IMM) ? CNT_W'(cmd.rep_imm - 5'h01) : cnt_ff;
  assign hit       = (cmd.rep == MACSR_REP_IMM && cmd.rep_imm != 5'h00) || (cmd.rep == MACSR_REP_REG);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MACSR_IDLE;
      cmd_ff   <= '0;
    end else if (ce) begin
      case (state_ff)
        MACSR_IDLE: begin
          if (accept && hit && start_cnt != '0) begin
            state_ff <= MACSR_RUN;
            cmd_ff   <= cmd;
          end
        end
        MACSR_RUN: begin
          if (irq_enter) begin
            state_ff <= MACSR_SUSP;
          end else if (cnt_ff == '0) begin
            state_ff <= MACSR_IDLE;
          end
        end
        MACSR_SUSP: begin
          if (irq_return) begin
            state_ff <= MACSR_RUN;
          end
        end
        default: begin
          state_ff <= MACSR_IDLE;
        end
      endcase
    end
  end

  // count and active flag; the sequence owns them over a software write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      act_ff <= 1'b0;
    end else if (ce) begin
      if (accept && hit) begin
        if (start_cnt == '0) begin
          cnt_ff <= '0;
          act_ff <= 1'b0;
        end else begin
          cnt_ff <= start_cnt - CNT_W'(1);
          act_ff <= 1'b1;
        end
      end else if (exec && state_ff == MACSR_RUN) begin
        if (cnt_ff == '0) begin
          act_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - CNT_W'(1);
        end
      end else if (wr && paddr == OFS_REPEAT) begin
        cnt_ff <= pwdata[CNT_W-1:0];
        act_ff <= pwdata[RW_ACT];
      end
    end
  end

  // ****************************************
  // apb slave, zero wait while ce is high
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (paddr == OFS_ACC_LOW) begin
        prdata_ff <= {16'h0000, acc_low_ff};
      end else if (paddr == OFS_ACC_HIGH) begin
        prdata_ff <= {16'h0000, acc_high_ff};
      end else if (paddr == OFS_STATUS) begin
        prdata_ff <= {16'h0000, pend_ff, 3'b000, sat_ff, guard_ff, ovf_ff, carry_ff, acc_guard_ff};
      end else if (paddr == OFS_CONTROL) begin
        prdata_ff <= {16'h0000, ctrl_ff};
      end else if (paddr == OFS_REPEAT) begin
        prdata_ff <= {16'h0000, act_ff, 2'b00, cnt_ff};
      end else if (paddr == OFS_TRAPFLAG) begin
        prdata_ff <= {25'h0000000, tflag_ff, 6'h00};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = ce;
  assign pslverr = psel && penable && !(paddr == OFS_ACC_LOW || paddr == OFS_ACC_HIGH ||
                   paddr == OFS_STATUS || paddr == OFS_CONTROL || paddr == OFS_REPEAT ||
                   paddr == OFS_TRAPFLAG);

  // ****************************************
  // assertions
  // ****************************************
  sequence s_event;
    ce && irq_event;
  endsequence
  property p_trap_latency;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_event ##1 ce [*2]) |-> ##1 trap_vec_fetch;
  endproperty
  a_trap_latency: assert property (p_trap_latency) else $error("trap fetch late");

  property p_pending_set;
    @(posedge ref_clk) disable iff (!rst_n) irq_event |=> (trap_req && tflag_ff);
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set");

  property p_no_irq_disabled;
    @(posedge ref_clk) disable iff (!rst_n)
      (!ctrl_ff[CW_MIE] && !(wr && paddr == OFS_STATUS)) |=> $stable(trap_req);
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");

  property p_shr_keeps_carry;
    @(posedge ref_clk) disable iff (!rst_n)
      (exec && cur.op == MACSR_SHR && !(wr && paddr == OFS_STATUS)) |=> $stable(carry_ff);
  endproperty
  a_shr_keeps_carry: assert property (p_shr_keeps_carry) else $error("carry moved on right shift");

  property p_round_clears_low;
    @(posedge ref_clk) disable iff (!rst_n) (exec && cur.op == MACSR_RND) |=> acc_low_ff == 16'h0000;
  endproperty
  a_round_clears_low: assert property (p_round_clears_low) else $error("low word not cleared");

  property p_imm_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (accept && cmd.rep == MACSR_REP_IMM && cmd.rep_imm > 5'h01) |=>
        cnt_ff == CNT_W'($past(cmd.rep_imm) - 5'h02) && act_ff;
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("immediate count wrong");

  property p_susp_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_ff == MACSR_SUSP && !(wr && paddr == OFS_REPEAT)) |=> act_ff && $stable(cnt_ff);
  endproperty
  a_susp_holds: assert property (p_susp_holds) else $error("suspended repeat moved");

  property p_run_active;
    @(posedge ref_clk) disable iff (!rst_n) state_ff == MACSR_RUN |-> act_ff && !cmd_ready;
  endproperty
  a_run_active: assert property (p_run_active) else $error("active flag low while running");

  property p_sat_value;
    @(posedge ref_clk) disable iff (!rst_n)
      (exec && set_sat && cur.op != MACSR_RND) |=> (acc == SAT_POS || acc == SAT_NEG) && sat_ff;
  endproperty
  a_sat_value: assert property (p_sat_value) else $error("saturation value wrong");

  property p_trap_id;
    @(posedge ref_clk) disable iff (!rst_n) trap_vec_fetch |-> trap_number == TRAP_NUMBER && trap_prio == TRAP_PRIO;
  endproperty
  a_trap_id: assert property (p_trap_id) else $error("trap identity wrong");
endmodule // macsr_core

// ---- testbench/macsr_cpu_model.sv ----
// cpu pipeline model issuing coprocessor instructions and interrupts
`timescale 1ns/1ns
module macsr_cpu_model (
  input  wire logic             ref_clk,
  input  wire logic             cmd_ready,
  output logic                  cmd_valid,
  output macsr_pkg::macsr_cmd_t cmd,
  output logic                  irq_enter,
  output logic                  irq_return
);
  import macsr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    irq_enter = 1'b0;
    irq_return = 1'b0;
  end
  // ****
  // issue
  // ****
  // hold until taken; idle bus is scrambled so a stale word never looks valid
  task automatic issue(input macsr_cmd_t c, output int waited);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    waited = n;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= ~c;
  endtask
  // one cycle entry or return pulse
  task automatic pulse(input logic ret);
    @(posedge ref_clk);
    if (ret) irq_return <= 1'b1;
    else irq_enter <= 1'b1;
    @(posedge ref_clk);
    irq_return <= 1'b0;
    irq_enter <= 1'b0;
  endtask
endmodule // macsr_cpu_model

// ---- testbench/testbench.sv ----
// self-checking bench of the shift, repeat and trap control block
`timescale 1ns/1ns
module testbench;
  import macsr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        irq_enter;
  logic        irq_return;
  logic        trap_req;
  logic        trap_vec_fetch;
  logic [7:0]  trap_number;
  logic [1:0]  trap_prio;
  logic [15:0] trap_ret_addr;
  macsr_cmd_t  cmd;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n;
  always #20 ref_clk = ~ref_clk;
  macsr_core macsr_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .irq_enter(irq_enter), .irq_return(irq_return), .trap_req(trap_req),
    .trap_vec_fetch(trap_vec_fetch), .trap_number(trap_number), .trap_prio(trap_prio),
    .trap_ret_addr(trap_ret_addr));
  macsr_cpu_model macsr_cpu_model_inst (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd(cmd), .irq_enter(irq_enter), .irq_return(irq_return));
  // ****
  // tasks
  // ****
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic limit;
    if (n >= 100) begin
      fail_count++;
      final_report;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    limit;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  // status write also loads every flag from fl
  task automatic setacc(input logic [39:0] v, input logic [7:0] fl);
    wr(OFS_STATUS, {16'h0, fl, v[39:32]});
    wr(OFS_ACC_HIGH, {16'h0, v[31:16]});
    wr(OFS_ACC_LOW, {16'h0, v[15:0]});
  endtask
  task automatic chkacc(input logic [39:0] v, input logic [31:0] st);
    rdc(OFS_ACC_LOW, {16'h0, v[15:0]});
    rdc(OFS_ACC_HIGH, {16'h0, v[31:16]});
    rdc(OFS_STATUS, st);
  endtask
  task automatic wait_idle;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    limit;
  endtask
  task automatic run(input macsr_op_t o, input logic [3:0] s, input macsr_rep_t r, input logic [4:0] i);
    macsr_cmd_t c;
    c = '0;
    c.op = o;
    c.shamt = s;
    c.rep = r;
    c.rep_imm = i;
    c.next_addr = 16'h0c42;
    macsr_cpu_model_inst.issue(c, n);
    limit;
  endtask
  task automatic mac(input logic [15:0] a, input logic [15:0] b, input logic s);
    macsr_cmd_t c;
    c = '0;
    c.op = MACSR_MAC;
    c.a_signed = s;
    c.b_signed = s;
    c.op_a = a;
    c.op_b = b;
    macsr_cpu_model_inst.issue(c, n);
    limit;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdc(8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    cmp(err, 1'b1);
    cmp({trap_prio, trap_number}, {TRAP_PRIO, TRAP_NUMBER});
    setacc(40'h00_1234_5678, 8'h00);
    run(MACSR_SHL, 4'h4, MACSR_REP_NONE, 5'h0);
    chkacc(40'h01_2345_6780, 32'h0000_0401);
    setacc(40'h90_0000_0000, 8'h00);
    run(MACSR_SHL, 4'h1, MACSR_REP_NONE, 5'h0);
    chkacc(40'h20_0000_0000, 32'h0000_0720);
    setacc(40'h80_0000_0010, 8'h01);
    run(MACSR_SHR, 4'h4, MACSR_REP_NONE, 5'h0);
    chkacc(40'hf8_0000_0001, 32'h0000_01f8);
    wr(OFS_CONTROL, 32'h0000_0002);
    setacc(40'h00_4000_0000, 8'h00);
    run(MACSR_SHL, 4'h1, MACSR_REP_NONE, 5'h0);
    chkacc(40'h00_7fff_ffff, 32'h0000_0800);
    wr(OFS_CONTROL, 32'h0);
    setacc(40'h00_1234_8000, 8'h00);
    run(MACSR_RND, 4'h0, MACSR_REP_NONE, 5'h0);
    chkacc(40'h00_1235_0000, 32'h0);
    // fractional signed product, then unsigned product with top bit set
    wr(OFS_CONTROL, 32'h0000_0001);
    setacc(40'h0, 8'h00);
    mac(16'hc000, 16'h4000, 1'b1);
    chkacc(40'hff_e000_0000, 32'h0000_00ff);
    wr(OFS_CONTROL, 32'h0);
    setacc(40'h0, 8'h00);
    mac(16'hffff, 16'hffff, 1'b0);
    chkacc(40'h00_fffe_0001, 32'h0000_0400);
    // immediate repeat: three shifts of one bit
    setacc(40'h00_0000_0001, 8'h00);
    run(MACSR_SHL, 4'h1, MACSR_REP_IMM, 5'h3);
    @(negedge ref_clk);
    cmp(cmd_ready, 1'b0);
    // ce low after the second pass must hold back the last one
    @(posedge ref_clk);
    ce <= 1'b0;
    @(negedge ref_clk);
    cmp(pready, 1'b0);
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    wait_idle;
    cmp(40'(n), 40'h2);
    chkacc(40'h00_0000_0008, 32'h0);
    rdc(OFS_REPEAT, 32'h0);
    // register repeat of five, suspended after two
    setacc(40'h00_0000_0001, 8'h00);
    wr(OFS_REPEAT, 32'h0000_0004);
    @(posedge ref_clk);
    run(MACSR_SHL, 4'h1, MACSR_REP_REG, 5'h0);
    macsr_cpu_model_inst.pulse(1'b0);
    rdc(OFS_REPEAT, 32'h0000_8002);
    wr(OFS_REPEAT, 32'h0000_8002);
    chkacc(40'h00_0000_0004, 32'h0);
    macsr_cpu_model_inst.pulse(1'b1);
    wait_idle;
    chkacc(40'h00_0000_0020, 32'h0);
    rdc(OFS_REPEAT, 32'h0);
    // carry trap: masked off globally, then enabled
    wr(OFS_CONTROL, 32'h0000_0100);
    setacc(40'h80_0000_0000, 8'h00);
    run(MACSR_SHL, 4'h1, MACSR_REP_NONE, 5'h0);
    @(negedge ref_clk);
    cmp(trap_req, 1'b0);
    wr(OFS_CONTROL, 32'h0000_8100);
    setacc(40'h80_0000_0000, 8'h00);
    run(MACSR_SHL, 4'h1, MACSR_REP_NONE, 5'h0);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (trap_vec_fetch !== 1'b1 && n < 100);
    limit;
    cmp(40'(n), 40'(TRAP_LAT));
    cmp({trap_req, trap_ret_addr}, {1'b1, 16'h0c42});
    rdc(OFS_STATUS, 32'h0000_8300);
    rdc(OFS_TRAPFLAG, 32'h0000_0040);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_TRAPFLAG, 32'h0);
    cmp(trap_req, 1'b0);
    rdc(OFS_TRAPFLAG, 32'h0);
    final_report;
  end
endmodule // testbench
